// >>> dbg_trig_pkg.sv
package dbg_trig_pkg;

    // Trigger count and pairing
    localparam int NUM_TRIG = 8;
    localparam int ADDR_W = 32;
    localparam int TASK_W = 8;
    localparam int CFG_W = 8;
    localparam int CREG_W = 16;

    // Dedicated debug register window, never raises an event
    localparam logic [15:0] DBG_REG_LO = 16'hf000;
    localparam logic [15:0] DBG_REG_HI = 16'hfdff;

    // Reset values
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
    localparam logic [NUM_TRIG-1:0] ACC_RST = 8'h00;

    // Trigger event configuration fields
    typedef struct packed {
        logic [TASK_W-1:0] task_identifier_field;
        logic task_match_enable;
        logic range_enable_bit;
        logic on_exec;
        logic on_load;
        logic on_store;
        logic [CFG_W-1:0] action;
    } trigger_event_cfg_t;

    // One access presented to the comparators
    typedef struct packed {
        logic fetch_valid;
        logic [ADDR_W-1:0] fetch_vaddr;
        logic load_valid;
        logic store_valid;
        logic [ADDR_W-1:0] data_vaddr;
    } access_t;

    // Event source codes
    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_EXT = 3'b001,
        SRC_SW = 3'b010,
        SRC_CREG = 3'b011,
        SRC_TRIG = 3'b100
    } event_src_t;

endpackage : dbg_trig_pkg

// >>> debug_event_trigger_unit.sv
`timescale 1ns/1ps
`default_nettype none
module debug_event_trigger_unit
    import dbg_trig_pkg::*;
#(
    parameter int N_TRIG = NUM_TRIG
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic debug_enable_bit,
    input wire logic break_in,
    input wire logic noncancel_busy,
    input wire logic sw_debug_short,
    input wire logic sw_debug_long,
    input wire logic creg_move_valid,
    input wire logic [CREG_W-1:0] creg_move_addr,
    input wire logic creg_is_user_core_special_function_register,
    input wire logic [CFG_W-1:0] external_event_cfg,
    input wire logic [CFG_W-1:0] software_event_cfg,
    input wire logic [CFG_W-1:0] core_reg_access_event_cfg,
    input wire dbg_trig_pkg::trigger_event_cfg_t trigger_event_cfg [N_TRIG],
    input wire logic [ADDR_W-1:0] trigger_address_reg [N_TRIG],
    input wire logic [TASK_W-1:0] current_task_id_reg,
    input wire dbg_trig_pkg::access_t access_in,
    input wire logic acc_read,
    output logic event_valid,
    output dbg_trig_pkg::event_src_t event_src,
    output logic [CFG_W-1:0] event_action,
    output logic [N_TRIG-1:0] event_trig_hits,
    output logic [N_TRIG-1:0] accumulated_trigger_reg,
    output logic break_pending
);
    logic [N_TRIG-1:0] hit;
    logic [N_TRIG-1:0] active;
    logic [N_TRIG-1:0] range_on;
    logic creg_evt;
    logic sw_evt;
    logic trig_evt;
    logic brk_go;
    logic [CFG_W-1:0] trig_action;
    logic brk_r;
    logic brk_nxt;
    logic ev_r;
    logic ev_nxt;
    event_src_t src_r;
    event_src_t src_nxt;
    logic [CFG_W-1:0] act_r;
    logic [CFG_W-1:0] act_nxt;
    logic [N_TRIG-1:0] hits_r;
    logic [N_TRIG-1:0] hits_nxt;
    logic [N_TRIG-1:0] acc_r;
    logic [N_TRIG-1:0] acc_nxt;

    // Even triggers own the range bit; odd ones never do
    always_comb
    begin
        range_on = '0;
        for (int i = 0; i + 1 < N_TRIG; i += 2)
        begin
            range_on[i] = trigger_event_cfg[i].range_enable_bit;
        end
    end

    // One comparator per trigger, upper limit from the odd neighbour
    for (genvar g = 0; g < N_TRIG; g++)
    begin : g_trig
        localparam int HI = (g + 1 < N_TRIG) ? g + 1 : g;
        trig_compare u_cmp
        (
            .cfg(trigger_event_cfg[g]),
            .lo_addr(trigger_address_reg[g]),
            .hi_addr(trigger_address_reg[HI]),
            .range_mode(range_on[g]),
            .acc(access_in),
            .current_task_id_reg(current_task_id_reg),
            .hit(hit[g])
        );
    end

    // An odd trigger consumed by a range is silent, so only even bit records
    always_comb
    begin
        active = hit;
        for (int i = 1; i < N_TRIG; i += 2)
        begin
            if (range_on[i-1])
            begin
                active[i] = 1'b0;
            end
        end
        trig_action = '0;
        for (int i = N_TRIG - 1; i >= 0; i--)
        begin
            if (active[i])
            begin
                trig_action = trigger_event_cfg[i].action;
            end
        end
    end

    // Only user special registers outside the debug window count
    assign creg_evt = creg_move_valid && creg_is_user_core_special_function_register &&
        !((creg_move_addr >= DBG_REG_LO) &&
        (creg_move_addr <= DBG_REG_HI));
    assign sw_evt = sw_debug_short || sw_debug_long;
    assign trig_evt = |active;
    // Break-in is held until the core can take it; it is dropped while debug_enable_bit is low
    assign brk_go = (brk_r || break_in) && !noncancel_busy;

    // Source selection; lowest priority sources wait a cycle only via re-present
    always_comb
    begin
        brk_nxt = brk_r;
        ev_nxt = 1'b0;
        src_nxt = SRC_NONE;
        act_nxt = '0;
        hits_nxt = '0;
        if (!debug_enable_bit)
        begin
            brk_nxt = 1'b0;
        end
        else
        begin
            brk_nxt = (brk_r || break_in) && noncancel_busy;
            if (brk_go)
            begin
                ev_nxt = 1'b1;
                src_nxt = SRC_EXT;
                act_nxt = external_event_cfg;
            end
            else if (sw_evt)
            begin
                ev_nxt = 1'b1;
                src_nxt = SRC_SW;
                act_nxt = software_event_cfg;
            end
            else if (creg_evt)
            begin
                ev_nxt = 1'b1;
                src_nxt = SRC_CREG;
                act_nxt = core_reg_access_event_cfg;
            end
            else if (trig_evt)
            begin
                ev_nxt = 1'b1;
                src_nxt = SRC_TRIG;
                act_nxt = trig_action;
                hits_nxt = active;
            end
        end
    end

    // Record survives a read in the same cycle as a new activation
    always_comb
    begin
        acc_nxt = acc_read ? active : (acc_r | active);
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            brk_r <= 1'b0;
            ev_r <= 1'b0;
            src_r <= SRC_NONE;
            act_r <= CFG_RST;
            hits_r <= ACC_RST;
            acc_r <= ACC_RST;
        end
        else
        begin
            brk_r <= brk_nxt;
            ev_r <= ev_nxt;
            src_r <= src_nxt;
            act_r <= act_nxt;
            hits_r <= hits_nxt;
            acc_r <= acc_nxt;
        end
    end

    assign event_valid = ev_r;
    assign event_src = src_r;
    assign event_action = act_r;
    assign event_trig_hits = hits_r;
    assign accumulated_trigger_reg = acc_r;
    assign break_pending = brk_r;

    // Checks
    property p_no_evt_disabled;
        @(posedge ref_clk) disable iff (sys_rst)
        !debug_enable_bit |=> !event_valid;
    endproperty
    a_no_evt_disabled: assert property (p_no_evt_disabled)
        else $error("event while disabled");

    property p_brk_wait;
        @(posedge ref_clk) disable iff (sys_rst)
        debug_enable_bit && break_in && noncancel_busy |=> break_pending;
    endproperty
    a_brk_wait: assert property (p_brk_wait)
        else $error("break-in lost while busy");

    property p_brk_action;
        @(posedge ref_clk) disable iff (sys_rst)
        debug_enable_bit && brk_go |=>
            event_valid && event_src == SRC_EXT &&
            event_action == $past(external_event_cfg);
    endproperty
    a_brk_action: assert property (p_brk_action)
        else $error("break-in event wrong");

    property p_sw_evt;
        @(posedge ref_clk) disable iff (sys_rst)
        debug_enable_bit && !brk_go && (sw_debug_short || sw_debug_long) |=>
            event_valid && event_src == SRC_SW &&
            event_action == $past(software_event_cfg);
    endproperty
    a_sw_evt: assert property (p_sw_evt)
        else $error("debug instruction event wrong");

    property p_dbg_window;
        @(posedge ref_clk) disable iff (sys_rst)
        creg_move_valid && creg_move_addr >= DBG_REG_LO &&
            creg_move_addr <= DBG_REG_HI && !sw_evt && !brk_go && !trig_evt
            |=> !event_valid;
    endproperty
    a_dbg_window: assert property (p_dbg_window)
        else $error("debug register move raised event");

    property p_acc_set;
        @(posedge ref_clk) disable iff (sys_rst)
        active[0] |=> accumulated_trigger_reg[0];
    endproperty
    a_acc_set: assert property (p_acc_set)
        else $error("trigger not recorded");

    property p_acc_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        acc_read && !(|active) |=> accumulated_trigger_reg == '0;
    endproperty
    a_acc_clear: assert property (p_acc_clear)
        else $error("read did not clear");

    property p_range_odd;
        @(posedge ref_clk) disable iff (sys_rst)
        range_on[0] && !acc_read |=>
            accumulated_trigger_reg[1] == $past(accumulated_trigger_reg[1]);
    endproperty
    a_range_odd: assert property (p_range_odd)
        else $error("odd range bit recorded");

    property p_src_code;
        @(posedge ref_clk) disable iff (sys_rst)
        event_valid == (event_src != SRC_NONE);
    endproperty
    a_src_code: assert property (p_src_code)
        else $error("event source code out of step with valid");

    property p_brk_drop;
        @(posedge ref_clk) disable iff (sys_rst)
        !debug_enable_bit |=> !break_pending;
    endproperty
    a_brk_drop: assert property (p_brk_drop)
        else $error("break-in kept while disabled");

    // Move to a user register outside the debug window, nothing above it
    property p_creg_evt;
        @(posedge ref_clk) disable iff (sys_rst)
        debug_enable_bit && !brk_go && !sw_evt && creg_move_valid &&
            creg_is_user_core_special_function_register &&
            (creg_move_addr < DBG_REG_LO || creg_move_addr > DBG_REG_HI)
            |=> event_valid && event_src == SRC_CREG &&
            event_action == $past(core_reg_access_event_cfg);
    endproperty
    a_creg_evt: assert property (p_creg_evt)
        else $error("register move event wrong");

    property p_perf_quiet;
        @(posedge ref_clk) disable iff (sys_rst)
        creg_move_valid && !creg_is_user_core_special_function_register && !sw_evt && !brk_go &&
            !trig_evt |=> !event_valid;
    endproperty
    a_perf_quiet: assert property (p_perf_quiet)
        else $error("non-user register move raised event");

    // Trigger 0 alone: the event carries its own action and hit bit
    property p_trig_action;
        @(posedge ref_clk) disable iff (sys_rst)
        debug_enable_bit && !brk_go && !sw_evt && !creg_evt && active[0]
            |=> event_valid && event_src == SRC_TRIG && event_trig_hits[0] &&
            event_action == $past(trigger_event_cfg[0].action);
    endproperty
    a_trig_action: assert property (p_trig_action)
        else $error("trigger event action wrong");

    property p_trig_idle;
        @(posedge ref_clk) disable iff (sys_rst)
        !trigger_event_cfg[0].on_exec && !trigger_event_cfg[0].on_load &&
            !trigger_event_cfg[0].on_store |-> !hit[0];
    endproperty
    a_trig_idle: assert property (p_trig_idle)
        else $error("trigger fired with no access kind");

    // Fetch inside range 0 is recorded on the even bit
    property p_range_fire;
        @(posedge ref_clk) disable iff (sys_rst)
        range_on[0] && trigger_event_cfg[0].on_exec &&
            !trigger_event_cfg[0].task_match_enable &&
            access_in.fetch_valid &&
            access_in.fetch_vaddr >= trigger_address_reg[0] &&
            access_in.fetch_vaddr < trigger_address_reg[1]
            |=> accumulated_trigger_reg[0];
    endproperty
    a_range_fire: assert property (p_range_fire)
        else $error("fetch in range not recorded");

    property p_task_block;
        @(posedge ref_clk) disable iff (sys_rst)
        trigger_event_cfg[0].task_match_enable &&
            trigger_event_cfg[0].task_identifier_field != current_task_id_reg
            |-> !hit[0];
    endproperty
    a_task_block: assert property (p_task_block)
        else $error("trigger fired for another task");

    c_brk: cover property (@(posedge ref_clk) event_src == SRC_EXT);
    c_trig: cover property (@(posedge ref_clk) event_src == SRC_TRIG);
    c_range: cover property (@(posedge ref_clk) range_on[0] && active[0]);
    c_creg: cover property (@(posedge ref_clk) event_src == SRC_CREG);
    c_sw: cover property (@(posedge ref_clk) event_src == SRC_SW);
endmodule : debug_event_trigger_unit
`default_nettype wire

// >>> on_chip_debug_support_model.sv
`timescale 1ns/1ps
`default_nettype none
// Debug support side: raises break-in a few cycles after a request
module on_chip_debug_support_model
#(
    parameter int DELAY = 3
)
(
    input wire logic ref_clk,
    input wire logic req,
    output logic break_in
);
    logic [3:0] cnt_r = 4'h0;
    logic pulse_r = 1'b0;
    assign break_in = pulse_r;
    // One-cycle pulse, so a busy core must hold it pending itself
    always @(posedge ref_clk)
    begin
        pulse_r <= (cnt_r == 4'h1);
        if (req)
            cnt_r <= 4'(DELAY);
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
    end
endmodule : on_chip_debug_support_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dbg_trig_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic enable = 1'b0;
    logic busy = 1'b0;
    logic sw_s = 1'b0;
    logic sw_l = 1'b0;
    logic cr_v = 1'b0;
    logic [15:0] a16 = 16'h0000;
    logic cr_u = 1'b0;
    logic [7:0] ext_cfg = 8'h00;
    logic [7:0] sw_cfg = 8'h00;
    logic [7:0] cr_cfg = 8'h00;
    trigger_event_cfg_t tc [NUM_TRIG];
    logic [ADDR_W-1:0] ta [NUM_TRIG];
    logic [7:0] tid = 8'h00;
    access_t acc = '0;
    logic acc_read = 1'b0;
    logic brk_req = 1'b0;
    logic break_in, ev_v, pend, h;
    event_src_t ev_s;
    logic [7:0] ev_a, hits, acc_bits;
    logic [31:0] lo, sp, a;
    trigger_event_cfg_t c;
    int k, md;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;

    always #20 ref_clk = ~ref_clk;

    on_chip_debug_support_model u_on_chip_debug_support_model (.ref_clk(ref_clk), .req(brk_req),
        .break_in(break_in));

    debug_event_trigger_unit u_debug_event_trigger_unit (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .debug_enable_bit(enable),
        .break_in(break_in), .noncancel_busy(busy),
        .sw_debug_short(sw_s), .sw_debug_long(sw_l),
        .creg_move_valid(cr_v), .creg_move_addr(a16),
        .creg_is_user_core_special_function_register(cr_u), .external_event_cfg(ext_cfg),
        .software_event_cfg(sw_cfg), .core_reg_access_event_cfg(cr_cfg),
        .trigger_event_cfg(tc), .trigger_address_reg(ta),
        .current_task_id_reg(tid), .access_in(acc), .acc_read(acc_read),
        .event_valid(ev_v), .event_src(ev_s), .event_action(ev_a),
        .event_trig_hits(hits), .accumulated_trigger_reg(acc_bits),
        .break_pending(pend));

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // Event outputs stand one cycle, so they are looked at right away
    task automatic chk_evt(input logic v, input event_src_t s,
        input logic [7:0] e);
        total_checks++;
        if (ev_v !== v || (v && (ev_s !== s || ev_a !== e)))
        begin
            miscompares++;
            $display("unexpected event at %0t got %h %h %h exp %h %h %h",
                $time, ev_v, ev_s, ev_a, v, s, e);
        end
    endtask : chk_evt

    task automatic chk_vec(input logic [7:0] got, input logic [7:0] e);
        total_checks++;
        if (got !== e)
        begin
            miscompares++;
            $display("unexpected bits at %0t got %h exp %h", $time, got, e);
        end
    endtask : chk_vec

    // Inputs change only at the falling edge
    task automatic go();
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : go

    function automatic logic exp_creg(input logic [15:0] ad, input logic u);
        return u && !(ad >= 16'hf000 && ad <= 16'hfdff);
    endfunction : exp_creg

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    initial
    begin
        for (int n = 0; n < NUM_TRIG; n++)
        begin
            tc[n] = '0;
            ta[n] = '0;
        end
        void'($urandom(32'h8d72));
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'b0;
        go();
        // Sources while disabled leave no trace
        sw_s = 1'b1;
        cr_v = 1'b1;
        cr_u = 1'b1;
        go();
        chk_evt(1'b0, SRC_NONE, 8'h00);
        cr_v = 1'b0;
        enable = 1'b1;
        // Back-to-back debug instructions in both encodings
        for (int j = 0; j < 4; j++)
        begin
            sw_cfg = 8'($urandom);
            sw_s = j[0];
            sw_l = !j[0];
            go();
            chk_evt(1'b1, SRC_SW, sw_cfg);
        end
        sw_s = 1'b0;
        sw_l = 1'b0;
        // Register moves: window edges first, then random addresses
        for (int j = 0; j < 24; j++)
        begin
            a16 = j == 0 ? 16'hf000 : j == 1 ? 16'hfdff :
                j == 2 ? 16'hefff : j == 3 ? 16'hfe00 : 16'($urandom);
            cr_u = (j < 4) || $urandom_range(1, 0);
            cr_cfg = 8'($urandom);
            cr_v = 1'b1;
            go();
            chk_evt(exp_creg(a16, cr_u), SRC_CREG, cr_cfg);
        end
        // Two sources at once: the debug instruction outranks the move
        sw_l = 1'b1;
        go();
        chk_evt(1'b1, SRC_SW, sw_cfg);
        sw_l = 1'b0;
        cr_v = 1'b0;
        // Break-in on an idle core, then on a busy one
        for (int j = 0; j < 2; j++)
        begin
            ext_cfg = 8'($urandom);
            busy = j[0];
            brk_req = 1'b1;
            go();
            brk_req = 1'b0;
            if (j == 1)
            begin
                repeat (6) go();
                chk_vec({7'h00, pend}, 8'h01);
                chk_evt(1'b0, SRC_NONE, 8'h00);
                busy = 1'b0;
                go();
            end
            for (int w = 0; w < 8 && ev_v !== 1'b1; w++)
                go();
            chk_evt(1'b1, SRC_EXT, ext_cfg);
        end
        // Triggers: single or range, every access kind, task match
        for (int j = 0; j < 48; j++)
        begin
            k = 2 * $urandom_range(3, 0);
            lo = {1'b0, 31'($urandom)};
            sp = $urandom_range(64, 1);
            md = $urandom_range(2, 0);
            c = trigger_event_cfg_t'($urandom);
            c.range_enable_bit = j[2];
            c.on_exec = md == 0;
            c.on_load = md == 1;
            c.on_store = md == 2;
            for (int n = 0; n < NUM_TRIG; n++)
            begin
                tc[n] = '0;
                ta[n] = $urandom;
            end
            tc[k] = c;
            // In a range the odd twin would hit on its own address
            if (c.range_enable_bit)
                tc[k + 1] = c;
            tc[k + 1].range_enable_bit = $urandom_range(1, 0);
            ta[k] = lo;
            ta[k + 1] = lo + sp;
            tid = c.task_identifier_field ^ 8'($urandom_range(1, 0));
            a = (j % 4 == 0) ? lo : (j % 4 == 1) ? lo + sp - 1 :
                (j % 4 == 2) ? lo + sp : lo - 1;
            h = (c.range_enable_bit ? (a >= lo && a < lo + sp) : a == lo)
                && (!c.task_match_enable || tid == c.task_identifier_field);
            acc = '0;
            acc.fetch_valid = md == 0;
            acc.load_valid = md == 1;
            acc.store_valid = md == 2;
            acc.fetch_vaddr = a;
            acc.data_vaddr = a;
            go();
            acc = '0;
            chk_evt(h, SRC_TRIG, c.action);
            if (h)
                chk_vec(hits, 8'h01 << k);
            chk_vec(acc_bits, h ? 8'h01 << k : 8'h00);
            acc_read = 1'b1;
            go();
            acc_read = 1'b0;
            chk_vec(acc_bits, 8'h00);
        end
        // Reset in mid-run drops a pending break-in
        busy = 1'b1;
        brk_req = 1'b1;
        go();
        brk_req = 1'b0;
        repeat (4) go();
        chk_vec({7'h00, pend}, 8'h01);
        sys_rst = 1'b1;
        go();
        chk_vec({7'h00, pend}, 8'h00);
        sys_rst = 1'b0;
        busy = 1'b0;
        go();
        chk_evt(1'b0, SRC_NONE, 8'h00);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire

// >>> trig_compare.sv
`timescale 1ns/1ps
`default_nettype none
// One trigger's address comparison; range limit comes from the odd neighbour
module trig_compare
    import dbg_trig_pkg::*;
(
    input wire dbg_trig_pkg::trigger_event_cfg_t cfg,
    input wire logic [ADDR_W-1:0] lo_addr,
    input wire logic [ADDR_W-1:0] hi_addr,
    input wire logic range_mode,
    input wire dbg_trig_pkg::access_t acc,
    input wire logic [TASK_W-1:0] current_task_id_reg,
    output logic hit
);
    logic f_m;
    logic d_m;
    logic task_ok;

    // Virtual address compare, single or half-open range
    always_comb
    begin
        if (range_mode)
        begin
            f_m = (acc.fetch_vaddr >= lo_addr) && (acc.fetch_vaddr < hi_addr);
            d_m = (acc.data_vaddr >= lo_addr) && (acc.data_vaddr < hi_addr);
        end
        else
        begin
            f_m = (acc.fetch_vaddr == lo_addr);
            d_m = (acc.data_vaddr == lo_addr);
        end
        task_ok = !cfg.task_match_enable ||
            (cfg.task_identifier_field == current_task_id_reg);
        hit = task_ok && ((cfg.on_exec && acc.fetch_valid && f_m) ||
            (cfg.on_load && acc.load_valid && d_m) ||
            (cfg.on_store && acc.store_valid && d_m));
    end
endmodule : trig_compare
`default_nettype wire
